// File: spcms_pkg.sv
// Shared constants and types for the stream port configuration and message steering block.
package spcms_pkg;
    localparam logic [1:0] SPCMS_UCLK_62M5 = 2'h0;
    localparam logic [1:0] SPCMS_UCLK_125M = 2'h1;
    localparam logic [1:0] SPCMS_UCLK_250M = 2'h2;
    localparam logic [1:0] SPCMS_CODE_RSVD = 2'h3;
    localparam logic [1:0] SPCMS_WIDTH_64  = 2'h0;
    localparam logic [1:0] SPCMS_WIDTH_128 = 2'h1;
    localparam logic [1:0] SPCMS_WIDTH_256 = 2'h2;
    localparam int         SPCMS_MASK_BITS = 18;
    localparam int         SPCMS_TYPE_BITS = 5;
    localparam int         SPCMS_CORE_MHZ_FAST = 500;
    localparam int         SPCMS_CORE_MHZ_SLOW = 250;
    localparam logic [4:0] SPCMS_MSG_INVALID = 5'h11;
    localparam logic [7:0] SPCMS_ADDR_CFG    = 8'h00;
    localparam logic [7:0] SPCMS_ADDR_MASK   = 8'h04;
    localparam logic [7:0] SPCMS_ADDR_STATUS = 8'h08;
    localparam logic [7:0] SPCMS_ADDR_MSG    = 8'h0C;
    localparam logic [7:0] SPCMS_ADDR_COUNT  = 8'h10;
    localparam int         SPCMS_CFG_CORE    = 0;
    localparam int         SPCMS_CFG_UCLK    = 1;
    localparam int         SPCMS_CFG_WIDTH   = 3;
    localparam int         SPCMS_CFG_CQ      = 5;
    localparam int         SPCMS_CFG_CC      = 6;
    localparam int         SPCMS_CFG_RQ      = 7;
    localparam int         SPCMS_CFG_RC      = 8;
    localparam int         SPCMS_CFG_STRAD   = 9;
    localparam int         SPCMS_CFG_MSGPORT = 10;
    localparam int         SPCMS_CFG_PAR     = 11;
    localparam int         SPCMS_CFG_BITS    = 12;
    localparam logic [11:0] SPCMS_CFG_RESET  = 12'h000;
    localparam logic [17:0] SPCMS_MASK_RESET = 18'h3FFFF;

    typedef struct packed {
        logic        coreClockRateSelect;
        logic [1:0]  userClockRateCode;
        logic [1:0]  streamWidthCode;
        logic        completerRequestAlignSelect;
        logic        completerCompletionAlignSelect;
        logic        requesterRequestAlignSelect;
        logic        requesterCompletionAlignSelect;
        logic        completionStraddleEnable;
        logic        messagePortSelect;
        logic        requestParityCheckEnable;
    } spcms_cfg_t;

    typedef enum logic [1:0] {
        SPCMS_IDLE  = 2'b00,
        SPCMS_APPLY = 2'b01,
        SPCMS_RUN   = 2'b11,
        SPCMS_BAD   = 2'b10
    } spcms_state_t;
endpackage

// File: spcms_if.sv
// Interface joining the device end and the user application end.
`timescale 1ns/1ps
`default_nettype none
interface spcms_if;
    import spcms_pkg::*;
    spcms_cfg_t                 cfg;
    logic                       cfgLoad;
    logic [SPCMS_MASK_BITS-1:0] messageForwardMask;
    logic                       cfgAccepted;
    logic                       cfgIllegal;
    logic                       msgValid;
    logic [SPCMS_TYPE_BITS-1:0] msgType;
    logic                       msgOnCompleterRequestPort;
    logic                       msgOnRxMessagePort;
    logic                       msgDecoded;
    logic [SPCMS_TYPE_BITS-1:0] msgDecodedType;
    logic                       rqValid;
    logic [7:0]                 rqData;
    logic                       rqParity;
    logic                       rqParityError;
    logic                       straddleActive;

    modport device (input cfg, cfgLoad, messageForwardMask, rqValid, rqData, rqParity,
        output cfgAccepted, cfgIllegal, msgValid, msgType, msgOnCompleterRequestPort,
        msgOnRxMessagePort, msgDecoded, msgDecodedType, rqParityError, straddleActive);
    modport user (output cfg, cfgLoad, messageForwardMask, rqValid, rqData, rqParity,
        input cfgAccepted, cfgIllegal, msgValid, msgType, msgOnCompleterRequestPort,
        msgOnRxMessagePort, msgDecoded, msgDecodedType, rqParityError, straddleActive);
endinterface
`default_nettype wire

// File: spcms_msg_steer.sv
// Per-message steering decision for received messages.
`timescale 1ns/1ps
`default_nettype none
module spcms_msg_steer
(
    // Message in
    input  wire logic                                 msgIn,
    input  wire logic [spcms_pkg::SPCMS_TYPE_BITS-1:0] typeIn,
    // Configuration
    input  wire logic [spcms_pkg::SPCMS_MASK_BITS-1:0] forwardMask,
    input  wire logic                                 portSelect,
    // Decision
    output logic                                      toCompleterRequest,
    output logic                                      toRxMessage
);
    import spcms_pkg::*;
    logic forwardBit;
    logic [SPCMS_MASK_BITS-1:0] typeHot;
    genvar g;
    // Bits 0..17 select one message type each, in the fixed type order.
    generate
        for (g = 0; g < SPCMS_MASK_BITS; g++)
        begin : gHot
            assign typeHot[g] = (typeIn == SPCMS_TYPE_BITS'(g));
        end
    endgenerate
    assign forwardBit = |(typeHot & forwardMask);
    assign toCompleterRequest = msgIn && forwardBit && !portSelect;
    assign toRxMessage        = msgIn && forwardBit && portSelect;
endmodule
`default_nettype wire

// File: spcms_device.sv
// Device end: configuration decode, message steering and request parity check.
// How it works
// - Core clock select picks 500 or 250 MHz.
// - User clock code: 62.5, 125, 250, reserved.
// - Width code: 64, 128, 256 bits, reserved.
// - Completer request alignment: dword or address.
// - Completer completion alignment: dword or address.
// - Requester request alignment: dword or address.
// - Requester completion alignment: dword or address.
// - Completion straddling only when enabled at 256.
// - Message select routes completer request or message port.
// - Eighteen-bit mask forwards matching message types.
// - Every message received in the run state reaches the internal decoder.
// - Bits 0-6: error and legacy interrupt messages.
// - Bits 7-17: power, LTR, OBFF, vendor, invalid.
// - Parity check on requester requests when enabled.
`timescale 1ns/1ps
`default_nettype none
module spcms_device
(
    // Clock and reset
    input  wire logic                                 core_clk,
    input  wire logic                                 resetn,
    // Link to the user end
    spcms_if.device                                   link,
    // Decoded configuration status
    output logic [9:0]                                coreClockMhz,
    output logic [9:0]                                userClockMhzX2,
    output logic [8:0]                                dataPathBits,
    output logic [3:0]                                addressAlignedPorts,
    output logic                                      straddleAllowed,
    output logic                                      parityCheckOn,
    output logic                                      configGood,
    // Received message input
    input  wire logic                                 rxMsgValid,
    input  wire logic [spcms_pkg::SPCMS_TYPE_BITS-1:0] rxMsgType
);
    import spcms_pkg::*;

    typedef struct packed {
        spcms_state_t               state;
        spcms_cfg_t                 cfg;
        logic [SPCMS_MASK_BITS-1:0] mask;
        logic                       illegal;
        logic                       accepted;
        logic [9:0]                 coreMhz;
        logic [9:0]                 userMhzX2;
        logic [8:0]                 pathBits;
        logic [3:0]                 aligned;
        logic                       straddle;
        logic                       parityOn;
        logic                       good;
        logic                       msgValid;
        logic [SPCMS_TYPE_BITS-1:0] msgType;
        logic                       msgCq;
        logic                       msgRx;
        logic                       decoded;
        logic [SPCMS_TYPE_BITS-1:0] decodedType;
        logic                       parErr;
    } spcms_dev_state_t;

    spcms_dev_state_t st_r;
    spcms_dev_state_t st_nxt;
    logic             steerCq;
    logic             steerRx;
    logic             msgLive;

    assign msgLive = rxMsgValid && (st_r.state == SPCMS_RUN);

    spcms_msg_steer uSteer
    (
        .msgIn              (msgLive),
        .typeIn             (rxMsgType),
        .forwardMask        (st_r.mask),
        .portSelect         (st_r.cfg.messagePortSelect),
        .toCompleterRequest (steerCq),
        .toRxMessage        (steerRx)
    );

    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.accepted = 1'b0;
        st_nxt.msgValid = 1'b0;
        st_nxt.msgCq    = 1'b0;
        st_nxt.msgRx    = 1'b0;
        st_nxt.decoded  = 1'b0;
        st_nxt.parErr   = 1'b0;
        case (st_r.state)
            SPCMS_IDLE, SPCMS_RUN, SPCMS_BAD:
            begin
                if (link.cfgLoad)
                begin
                    st_nxt.cfg   = link.cfg;
                    st_nxt.mask  = link.messageForwardMask;
                    st_nxt.state = SPCMS_APPLY;
                end
            end
            SPCMS_APPLY:
            begin
                // Reserved codes would leave clock and width undefined, so refuse them.
                st_nxt.illegal = (st_r.cfg.userClockRateCode == SPCMS_CODE_RSVD)
                    || (st_r.cfg.streamWidthCode == SPCMS_CODE_RSVD);
                st_nxt.good     = !st_nxt.illegal;
                st_nxt.accepted = 1'b1;
                st_nxt.state    = st_nxt.illegal ? SPCMS_BAD : SPCMS_RUN;
                st_nxt.coreMhz  = st_r.cfg.coreClockRateSelect
                    ? 10'(SPCMS_CORE_MHZ_FAST) : 10'(SPCMS_CORE_MHZ_SLOW);
                case (st_r.cfg.userClockRateCode)
                    SPCMS_UCLK_62M5: st_nxt.userMhzX2 = 10'h07D;
                    SPCMS_UCLK_125M: st_nxt.userMhzX2 = 10'h0FA;
                    SPCMS_UCLK_250M: st_nxt.userMhzX2 = 10'h1F4;
                    default:         st_nxt.userMhzX2 = 10'h000;
                endcase
                case (st_r.cfg.streamWidthCode)
                    SPCMS_WIDTH_64:  st_nxt.pathBits = 9'h040;
                    SPCMS_WIDTH_128: st_nxt.pathBits = 9'h080;
                    SPCMS_WIDTH_256: st_nxt.pathBits = 9'h100;
                    default:         st_nxt.pathBits = 9'h000;
                endcase
                st_nxt.aligned = {st_r.cfg.requesterCompletionAlignSelect,
                                  st_r.cfg.requesterRequestAlignSelect,
                                  st_r.cfg.completerCompletionAlignSelect,
                                  st_r.cfg.completerRequestAlignSelect};
                st_nxt.straddle = st_r.cfg.completionStraddleEnable
                    && (st_r.cfg.streamWidthCode == SPCMS_WIDTH_256);
                st_nxt.parityOn = st_r.cfg.requestParityCheckEnable;
            end
            default:
            begin
                st_nxt.state = SPCMS_IDLE;
            end
        endcase
        if (msgLive)
        begin
            st_nxt.decoded     = 1'b1;
            st_nxt.decodedType = rxMsgType;
            st_nxt.msgValid    = steerCq || steerRx;
            st_nxt.msgType     = rxMsgType;
            st_nxt.msgCq       = steerCq;
            st_nxt.msgRx       = steerRx;
        end
        if (link.rqValid && st_r.parityOn && (st_r.state == SPCMS_RUN))
        begin
            // Even parity over the data byte and its parity bit.
            st_nxt.parErr = ^{link.rqData, link.rqParity};
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r       <= '0;
            st_r.state <= SPCMS_IDLE;
            st_r.cfg   <= SPCMS_CFG_RESET;
            st_r.mask  <= SPCMS_MASK_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign link.cfgAccepted               = st_r.accepted;
    assign link.cfgIllegal                = st_r.illegal;
    assign link.msgValid                  = st_r.msgValid;
    assign link.msgType                   = st_r.msgType;
    assign link.msgOnCompleterRequestPort = st_r.msgCq;
    assign link.msgOnRxMessagePort        = st_r.msgRx;
    assign link.msgDecoded                = st_r.decoded;
    assign link.msgDecodedType            = st_r.decodedType;
    assign link.rqParityError             = st_r.parErr;
    assign link.straddleActive            = st_r.straddle;
    assign coreClockMhz                   = st_r.coreMhz;
    assign userClockMhzX2                 = st_r.userMhzX2;
    assign dataPathBits                   = st_r.pathBits;
    assign addressAlignedPorts            = st_r.aligned;
    assign straddleAllowed                = st_r.straddle;
    assign parityCheckOn                  = st_r.parityOn;
    assign configGood                     = st_r.good;
endmodule
`default_nettype wire

// File: spcms_user.sv
// User end: software registers that program the device and observe its status.
`timescale 1ns/1ps
`default_nettype none
module spcms_user
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Software register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    // Requester request data source
    input  wire logic        rqSend,
    input  wire logic [7:0]  rqByte,
    // Link to the device
    spcms_if.user            link
);
    import spcms_pkg::*;

    typedef struct packed {
        logic [SPCMS_CFG_BITS-1:0]  cfg;
        logic [SPCMS_MASK_BITS-1:0] mask;
        logic                       load;
        logic                       rqValid;
        logic [7:0]                 rqData;
        logic                       rqParity;
        logic                       illegal;
        logic                       parErr;
        logic [SPCMS_TYPE_BITS-1:0] lastType;
        logic                       lastCq;
        logic                       lastRx;
        logic [15:0]                decodeCount;
        logic [31:0]                rdata;
    } spcms_usr_state_t;

    spcms_usr_state_t st_r;
    spcms_usr_state_t st_nxt;

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.load    = 1'b0;
        st_nxt.rqValid = rqSend;
        st_nxt.rqData  = rqByte;
        st_nxt.rqParity = ^rqByte;
        st_nxt.rdata   = 32'h00000000;
        if (link.cfgAccepted)
        begin
            st_nxt.illegal = link.cfgIllegal;
        end
        if (link.msgValid)
        begin
            st_nxt.lastType = link.msgType;
            st_nxt.lastCq   = link.msgOnCompleterRequestPort;
            st_nxt.lastRx   = link.msgOnRxMessagePort;
        end
        if (link.msgDecoded)
        begin
            st_nxt.decodeCount = st_r.decodeCount + 16'h0001;
        end
        if (regWrite && (regAddr == SPCMS_ADDR_CFG))
        begin
            st_nxt.cfg  = regWdata[SPCMS_CFG_BITS-1:0];
            st_nxt.load = 1'b1;
        end
        if (regWrite && (regAddr == SPCMS_ADDR_MASK))
        begin
            st_nxt.mask = regWdata[SPCMS_MASK_BITS-1:0];
        end
        // Sticky error: a new error in the clearing cycle wins over the clear.
        if (regWrite && (regAddr == SPCMS_ADDR_STATUS) && regWdata[1])
        begin
            st_nxt.parErr = 1'b0;
        end
        if (link.rqParityError)
        begin
            st_nxt.parErr = 1'b1;
        end
        if (regRead)
        begin
            case (regAddr)
                SPCMS_ADDR_CFG:    st_nxt.rdata = {20'h00000, st_r.cfg};
                SPCMS_ADDR_MASK:   st_nxt.rdata = {14'h0000, st_r.mask};
                SPCMS_ADDR_STATUS: st_nxt.rdata = {29'h00000000, link.straddleActive,
                                                   st_r.parErr, st_r.illegal};
                SPCMS_ADDR_MSG:    st_nxt.rdata = {25'h0000000, st_r.lastRx, st_r.lastCq,
                                                   st_r.lastType};
                SPCMS_ADDR_COUNT:  st_nxt.rdata = {16'h0000, st_r.decodeCount};
                default:           st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r      <= '0;
            st_r.cfg  <= SPCMS_CFG_RESET;
            st_r.mask <= SPCMS_MASK_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign link.cfgLoad = st_r.load;
    assign link.messageForwardMask = st_r.mask;
    assign link.rqValid = st_r.rqValid;
    assign link.rqData = st_r.rqData;
    assign link.rqParity = st_r.rqParity;
    assign link.cfg.coreClockRateSelect = st_r.cfg[SPCMS_CFG_CORE];
    assign link.cfg.userClockRateCode = st_r.cfg[SPCMS_CFG_UCLK +: 2];
    assign link.cfg.streamWidthCode = st_r.cfg[SPCMS_CFG_WIDTH +: 2];
    assign link.cfg.completerRequestAlignSelect = st_r.cfg[SPCMS_CFG_CQ];
    assign link.cfg.completerCompletionAlignSelect = st_r.cfg[SPCMS_CFG_CC];
    assign link.cfg.requesterRequestAlignSelect = st_r.cfg[SPCMS_CFG_RQ];
    assign link.cfg.requesterCompletionAlignSelect = st_r.cfg[SPCMS_CFG_RC];
    assign link.cfg.completionStraddleEnable = st_r.cfg[SPCMS_CFG_STRAD];
    assign link.cfg.messagePortSelect = st_r.cfg[SPCMS_CFG_MSGPORT];
    assign link.cfg.requestParityCheckEnable = st_r.cfg[SPCMS_CFG_PAR];
endmodule
`default_nettype wire

// File: spcms_assertions.sv
// Concurrent checks on the link between the device end and the user end.
`timescale 1ns/1ps
`default_nettype none
module spcms_assertions
(
    // Clock and reset
    input wire logic                                   core_clk,
    input wire logic                                   resetn,
    // User end to device
    input wire spcms_pkg::spcms_cfg_t                  cfg,
    input wire logic                                   cfgLoad,
    input wire logic [spcms_pkg::SPCMS_MASK_BITS-1:0]  messageForwardMask,
    input wire logic                                   rqValid,
    input wire logic [7:0]                             rqData,
    input wire logic                                   rqParity,
    // Device to user end
    input wire logic                                   cfgAccepted,
    input wire logic                                   cfgIllegal,
    input wire logic                                   msgValid,
    input wire logic [spcms_pkg::SPCMS_TYPE_BITS-1:0]  msgType,
    input wire logic                                   msgOnCompleterRequestPort,
    input wire logic                                   msgOnRxMessagePort,
    input wire logic                                   msgDecoded,
    input wire logic [spcms_pkg::SPCMS_TYPE_BITS-1:0]  msgDecodedType,
    input wire logic                                   rqParityError,
    input wire logic                                   straddleActive
);
    import spcms_pkg::*;
    // The mask is judged as it stood when the message was taken, one cycle earlier.
    logic [SPCMS_MASK_BITS-1:0] maskPrev_r;
    logic                       wantFwd;
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            maskPrev_r <= SPCMS_MASK_RESET;
        else
            maskPrev_r <= messageForwardMask;
    assign wantFwd = (msgDecodedType < 5'h12) && maskPrev_r[msgDecodedType];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    a_load_to_accept: assert property (cfgLoad ##1 !cfgLoad |=> cfgAccepted)
        else $error("Load was not accepted two cycles later.");
    a_accept_has_load: assert property (cfgAccepted |-> $past(cfgLoad, 2))
        else $error("Accept without a load.");
    a_reserved_rejected: assert property (cfgAccepted |=> cfgIllegal ==
        ($past(cfg.userClockRateCode, 3) == SPCMS_CODE_RSVD
        || $past(cfg.streamWidthCode, 3) == SPCMS_CODE_RSVD))
        else $error("Illegal flag does not match the codes.");
    a_decode_always: assert property (msgValid |->
        msgDecoded && msgDecodedType == msgType)
        else $error("Forwarded message not decoded.");
    a_forward_mask: assert property (msgDecoded |-> msgValid == wantFwd)
        else $error("Forwarding disagrees with the mask.");
    a_one_route: assert property (msgValid |->
        (msgOnCompleterRequestPort ^ msgOnRxMessagePort)
        && msgOnRxMessagePort == cfg.messagePortSelect)
        else $error("Wrong message route.");
    a_route_needs_valid: assert property (!msgValid |-> !msgOnCompleterRequestPort
        && !msgOnRxMessagePort)
        else $error("Route flag without a message.");
    a_straddle_gate: assert property (cfgAccepted |=> straddleActive ==
        ($past(cfg.completionStraddleEnable, 3)
        && $past(cfg.streamWidthCode, 3) == SPCMS_WIDTH_256))
        else $error("Straddle state wrong.");
    a_parity_even: assert property (rqValid |-> ^{rqData, rqParity} == 1'b0)
        else $error("Odd parity from the user end.");
    a_parity_cause: assert property (rqParityError |-> $past(rqValid)
        && ^{$past(rqData), $past(rqParity)} && cfg.requestParityCheckEnable)
        else $error("Parity error without cause.");
    cover property (cfgAccepted ##1 cfgIllegal);
    cover property (msgValid && msgOnRxMessagePort);
    cover property (msgDecoded && !msgValid);
    cover property (rqValid ##1 !rqParityError);
endmodule
`default_nettype wire

// File: test_spcms.sv
// Self-checking testbench joining both ends through the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module test_spcms;
    import spcms_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, rqSend = 1'b0;
    logic rxMsgValid = 1'b0;
    logic [7:0] regAddr = 8'h00, rqByte = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [4:0] rxMsgType = 5'h00;
    logic [9:0] coreClockMhz, userClockMhzX2;
    logic [8:0] dataPathBits;
    logic [3:0] addressAlignedPorts;
    logic straddleAllowed, parityCheckOn, configGood;
    int errorCnt = 0, comparisons = 0;
    spcms_if spcms_if_i ();
    spcms_device spcms_device_i (.core_clk(core_clk), .resetn(resetn), .link(spcms_if_i),
        .coreClockMhz(coreClockMhz), .userClockMhzX2(userClockMhzX2), .dataPathBits(dataPathBits),
        .addressAlignedPorts(addressAlignedPorts), .straddleAllowed(straddleAllowed),
        .parityCheckOn(parityCheckOn), .configGood(configGood), .rxMsgValid(rxMsgValid),
        .rxMsgType(rxMsgType));
    spcms_user spcms_user_i (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .rqSend(rqSend), .rqByte(rqByte), .link(spcms_if_i));
    spcms_assertions spcms_assertions_i (.core_clk(core_clk), .resetn(resetn),
        .cfg(spcms_if_i.cfg), .cfgLoad(spcms_if_i.cfgLoad), .rqValid(spcms_if_i.rqValid),
        .messageForwardMask(spcms_if_i.messageForwardMask), .rqData(spcms_if_i.rqData),
        .rqParity(spcms_if_i.rqParity), .cfgAccepted(spcms_if_i.cfgAccepted),
        .cfgIllegal(spcms_if_i.cfgIllegal), .msgValid(spcms_if_i.msgValid),
        .msgType(spcms_if_i.msgType), .msgDecoded(spcms_if_i.msgDecoded),
        .msgOnCompleterRequestPort(spcms_if_i.msgOnCompleterRequestPort),
        .msgOnRxMessagePort(spcms_if_i.msgOnRxMessagePort),
        .msgDecodedType(spcms_if_i.msgDecodedType), .rqParityError(spcms_if_i.rqParityError),
        .straddleActive(spcms_if_i.straddleActive));
    always #50 core_clk = ~core_clk;
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            errorCnt++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdata, e);
    endtask
    // Programs a configuration and waits, bounded, for the device to take it.
    task automatic setCfg(input logic [11:0] c);
        int n = 0;
        wr(SPCMS_ADDR_CFG, {20'h0, c});
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end while (spcms_if_i.cfgAccepted !== 1'b1 && n < 10);
        `CHK(spcms_if_i.cfgAccepted, 1'b1);
        @(posedge core_clk);
        #1;
    endtask
    task automatic sendMsg(input logic [4:0] t, logic [17:0] m, logic p, logic ok);
        logic f;
        f = ok && (t < 5'h12) && m[t];
        @(posedge core_clk);
        rxMsgValid <= 1'b1;
        rxMsgType <= t;
        @(posedge core_clk);
        rxMsgValid <= 1'b0;
        #1;
        `CHK(spcms_if_i.msgDecoded, ok);
        `CHK(spcms_if_i.msgValid, f);
        `CHK(spcms_if_i.msgOnCompleterRequestPort, f & !p);
        `CHK(spcms_if_i.msgOnRxMessagePort, f & p);
    endtask
    task automatic testReset();
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0);
        rd(SPCMS_ADDR_CFG, 32'h0);
        rd(SPCMS_ADDR_MASK, {14'h0, SPCMS_MASK_RESET});
        `CHK(configGood, 1'b0);
        $display("test reset done");
    endtask
    task automatic testDecode();
        logic [11:0] tbl [4] = '{12'h2A1, 12'hB4A, 12'hBF5, 12'h014};
        logic [1:0] u, w;
        logic s;
        foreach (tbl[i])
        begin
            setCfg(tbl[i]);
            u = tbl[i][2:1];
            w = tbl[i][4:3];
            s = tbl[i][9] && w == SPCMS_WIDTH_256;
            `CHK(coreClockMhz, tbl[i][0] ? 10'h1F4 : 10'h0FA);
            `CHK(userClockMhzX2, u == 2'h0 ? 10'h07D : u == 2'h1 ? 10'h0FA : 10'h1F4);
            `CHK(dataPathBits, w == 2'h0 ? 9'h040 : w == 2'h1 ? 9'h080 : 9'h100);
            `CHK(addressAlignedPorts, tbl[i][8:5]);
            `CHK(straddleAllowed, s);
            `CHK(parityCheckOn, tbl[i][11]);
            `CHK(configGood, 1'b1);
            rd(SPCMS_ADDR_STATUS, {29'h0, s, 2'h0});
        end
        $display("test decode done");
    endtask
    task automatic testMessages();
        wr(SPCMS_ADDR_MASK, 32'h0002AAAA);
        setCfg(12'h014);
        for (int t = 0; t < 20; t++)
            sendMsg(5'(t), 18'h2AAAA, 1'b0, 1'b1);
        wr(SPCMS_ADDR_MASK, 32'h00015555);
        setCfg(12'h414);
        for (int t = 0; t < 20; t++)
            sendMsg(5'(t), 18'h15555, 1'b1, 1'b1);
        rd(SPCMS_ADDR_MSG, 32'h00000050);
        rd(SPCMS_ADDR_COUNT, 32'h00000028);
        $display("test messages done");
    endtask
    task automatic testIllegal();
        logic [11:0] bad [2] = '{12'h006, 12'h018};
        foreach (bad[i])
        begin
            setCfg(bad[i]);
            `CHK(configGood, 1'b0);
            `CHK(dataPathBits, bad[i][4:3] == 2'h3 ? 9'h000 : 9'h040);
            rd(SPCMS_ADDR_STATUS, 32'h1);
            sendMsg(5'h00, 18'h3FFFF, 1'b0, 1'b0);
        end
        rd(SPCMS_ADDR_COUNT, 32'h00000028);
        $display("test illegal done");
    endtask
    task automatic testParity();
        logic [7:0] b [4] = '{8'h00, 8'h01, 8'h7F, 8'hFF};
        setCfg(12'h814);
        foreach (b[i])
        begin
            @(posedge core_clk);
            rqSend <= 1'b1;
            rqByte <= b[i];
            @(posedge core_clk);
            rqSend <= 1'b0;
            #1;
            `CHK(spcms_if_i.rqValid, 1'b1);
            `CHK({spcms_if_i.rqData, spcms_if_i.rqParity}, {b[i], ^b[i]});
            @(posedge core_clk);
            #1;
            `CHK(spcms_if_i.rqParityError, 1'b0);
        end
        rd(SPCMS_ADDR_STATUS, 32'h0);
        $display("test parity done");
    endtask
    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #2000000;
        errorCnt++;
        tallyAndFinish();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        testReset();
        testDecode();
        testMessages();
        testIllegal();
        testParity();
        @(posedge core_clk);
        resetn <= 1'b0;
        #1;
        `CHK(configGood, 1'b0);
        `CHK(spcms_if_i.messageForwardMask, SPCMS_MASK_RESET);
        tallyAndFinish();
    end
endmodule
`default_nettype wire
